// ===== inc/iesc_defines.svh
// Constants for the interrupt entry and sleep control block
`ifndef IESC_DEFINES_SVH
`define IESC_DEFINES_SVH

`define IESC_CTRL_OFS      8'h00
`define IESC_STAT_OFS      8'h04
`define IESC_MASK_OFS      8'h08
`define IESC_PEND_OFS      8'h0c
`define IESC_SP_OFS        8'h10
`define IESC_MODE_OFS      8'h14
`define IESC_FLAGS_OFS     8'hfc

`define IESC_CTRL_GIE      0
`define IESC_STAT_ENTRY    0
`define IESC_STAT_VECTOR   1
`define IESC_STAT_WAKE     2
`define IESC_STAT_W        3

`define IESC_FLAG_C        7
`define IESC_FLAG_Z        6
`define IESC_FLAG_S        5
`define IESC_FLAG_V        4
`define IESC_FLAG_D        3
`define IESC_FLAG_H        2
`define IESC_FLAG_LSB      2
`define IESC_FLAGS_RST     8'h00

`define IESC_NSRC          6
`define IESC_SP_RST        16'h0000
`define IESC_VEC_BASE      16'h0000
`define IESC_RESTART_ADDR  16'h000c

`define IESC_OP_NOP        8'hff
`define IESC_OP_STOP       8'h6f
`define IESC_OP_HALT       8'h7f

`define IESC_TPC_NS        50
`define IESC_STACK_CYC     48
`define IESC_VEC_CYC       9
`define IESC_EXT_LEAD_CYC  5
`define IESC_FETCH_CYC     (`IESC_STACK_CYC + `IESC_VEC_CYC + 1)
`define IESC_EXT_FETCH_CYC (`IESC_FETCH_CYC + `IESC_EXT_LEAD_CYC)

`define IESC_SLOT_PCL      8'd40
`define IESC_SLOT_PCH      8'd43
`define IESC_SLOT_FLG      8'd46
`define IESC_SLOT_VHI      8'd50
`define IESC_SLOT_VLO      8'd53

`endif

// ===== inc/iesc_pkg.sv
// Types shared by the interrupt entry and sleep control block
package iesc_pkg;
    typedef logic [31:0] iesc_word_t;
    typedef logic [15:0] iesc_addr_t;
    typedef logic [7:0]  iesc_byte_t;
    typedef enum logic [1:0] {
        IESC_RUN,
        IESC_ENTRY,
        IESC_HALT,
        IESC_STOP
    } iesc_mode_t;
endpackage

// ===== verif/iesc_mem_model.sv
// External program memory model for vector reads and stack pushes
`timescale 1ns/1ns
module iesc_mem_model (
    input  wire logic                 ref_clk,
    input  wire logic                 data_strobe_n,
    input  wire logic                 read_write_n,
    input  wire iesc_pkg::iesc_addr_t mem_addr,
    input  wire iesc_pkg::iesc_byte_t mem_wdata,
    output iesc_pkg::iesc_byte_t      mem_rdata
);
    import iesc_pkg::*;
    // Only one 256-byte page decoded, enough for vectors and a small stack
    iesc_byte_t mem [256];
    iesc_byte_t last_q;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h40 + 8'(i);
        last_q = 8'h00;
    end
    // Released bus toggles so a late sample never sees a stale byte
    assign mem_rdata = (!data_strobe_n && read_write_n) ? mem[mem_addr[7:0]] : ~last_q;
    always @(posedge ref_clk) begin
        last_q <= mem_rdata;
        if (!data_strobe_n && !read_write_n) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
endmodule

// ===== verif/tb.sv
// Testbench for interrupt entry, sleep control and flag register
`timescale 1ns/1ns
module tb;
    import iesc_pkg::*;
    logic       ref_clk, reset, hsel, hwrite, op_valid, instr_last, flag_load, hreadyout;
    logic       hresp, as_n, ds_n, rw_n, cpu_clk_en, osc_en, timer_run, pc_load, irq_out, oe;
    logic [1:0] htrans, core_req;
    logic [2:0] hsize;
    logic [3:0] ext_n;
    iesc_word_t haddr, hwdata, hrdata, rd;
    iesc_byte_t opcode, flag_in, mem_rdata, mem_wdata, flag_value;
    iesc_addr_t core_pc, mem_addr, pc_value;
    int         err_count, cmp_count, cyc, n;
    iesc_top uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_request_line_0(ext_n[0]), .ext_request_line_1(ext_n[1]),
        .ext_request_line_2(ext_n[2]), .ext_request_line_3(ext_n[3]), .core_req(core_req),
        .instr_last(instr_last), .op_valid(op_valid), .opcode(opcode), .core_pc(core_pc),
        .flag_load(flag_load), .flag_in(flag_in), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wdata_oe(oe), .address_strobe_n(as_n),
        .data_strobe_n(ds_n), .read_write_n(rw_n), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
        .timer_run(timer_run), .pc_load(pc_load), .pc_value(pc_value),
        .flag_value(flag_value), .irq_out(irq_out));
    iesc_mem_model mdl (.ref_clk(ref_clk), .data_strobe_n(ds_n), .read_write_n(rw_n),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ready and read data taken at the rising edge that ends each phase
    task wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        rd = hrdata;
        if (hreadyout !== 1'b1) err_count++;
    endtask
    task bus(input logic wr, input logic [7:0] a, input iesc_word_t wd);
        @(posedge ref_clk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        wait_ready();
    endtask
    task rdc(input logic [7:0] a, input iesc_word_t exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task wait_pc;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            @(negedge ref_clk);
        end while (pc_load !== 1'b1 && n < 200);
    endtask
    task sleep(input iesc_byte_t op);
        @(posedge ref_clk);
        op_valid <= 1'b1; opcode <= 8'hff;
        @(posedge ref_clk);
        opcode <= op;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task pulse_core(input logic [1:0] v);
        @(posedge ref_clk);
        core_req <= v;
        @(posedge ref_clk);
        core_req <= 2'b00;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Whole run is well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        {hsel, hwrite, op_valid, instr_last, flag_load} = 5'h00;
        {haddr, hwdata, htrans, core_req, hsize, opcode, flag_in} = '0;
        ext_n = 4'hf; core_pc = 16'h1234; reset = 1'b1;
        err_count = 0; cmp_count = 0; cyc = 0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        wait_pc();
        check(n, 1);
        check(pc_value, 16'h000c);
        rdc(8'hfc, 32'h0);
        bus(1'b1, 8'hfc, 32'hff);
        rdc(8'hfc, 32'hfc);
        @(posedge ref_clk);
        flag_load <= 1'b1; flag_in <= 8'hab;
        @(posedge ref_clk);
        flag_load <= 1'b0;
        rdc(8'hfc, 32'ha8);
        rdc(8'h40, 32'h0);
        $display("test flags done");
        bus(1'b1, 8'h10, 32'h100);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h08, 32'h3);
        pulse_core(2'b01);
        rdc(8'h0c, 32'h10);
        @(posedge ref_clk);
        instr_last <= 1'b1;
        @(posedge ref_clk);
        instr_last <= 1'b0;
        wait_pc();
        // Count starts one edge after the edge closing the sample cycle, so add that edge
        check(n + 1, 58);
        check(pc_value, 16'h4849);
        check({mdl.mem[8'hff], mdl.mem[8'hfe], mdl.mem[8'hfd]}, 24'h3412a8);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h3);
        check(irq_out, 1'b1);
        bus(1'b1, 8'h04, 32'h3);
        @(negedge ref_clk);
        check(irq_out, 1'b0);
        $display("test entry done");
        sleep(8'h7f);
        check({cpu_clk_en, osc_en, timer_run}, 3'b011);
        check({as_n, ds_n, rw_n}, 3'b111);
        check(mem_addr, 16'h0009);
        check({hresp, oe}, 2'b00);
        rdc(8'h14, 32'h402);
        @(posedge ref_clk);
        ext_n[2] <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check(cpu_clk_en, 1'b1);
        rdc(8'h0c, 32'h4);
        rdc(8'h04, 32'h4);
        bus(1'b1, 8'h08, 32'h4);
        @(negedge ref_clk);
        check(irq_out, 1'b1);
        @(posedge ref_clk);
        ext_n[2] <= 1'b1;
        $display("test halt done");
        sleep(8'h6f);
        check({cpu_clk_en, osc_en, timer_run}, 3'b000);
        pulse_core(2'b10);
        repeat (4) @(posedge ref_clk);
        check(osc_en, 1'b0);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        wait_pc();
        check({n[7:0], pc_value, osc_en}, 25'h02_0018 | 25'h1);
        $display("test stop done");
        report_and_stop();
    end
endmodule

// ===== verilog/iesc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module iesc_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [W-1:0] lvl_next;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
        end
    end

    // Idle level is high: request lines are active low
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s1_reg  <= '1;
            s2_reg  <= '1;
            s3_reg  <= '1;
            lvl_reg <= '1;
        end else begin
            s1_reg  <= pin_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule

// ===== verilog/iesc_top.sv
// Interrupt entry sequencer, sleep control and flag register with AHB-Lite slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "iesc_defines.svh"
module iesc_top (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                hsel,
    input  wire iesc_pkg::iesc_word_t haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire iesc_pkg::iesc_word_t hwdata,
    input  wire logic                hready,
    output iesc_pkg::iesc_word_t     hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                ext_request_line_0,
    input  wire logic                ext_request_line_1,
    input  wire logic                ext_request_line_2,
    input  wire logic                ext_request_line_3,
    input  wire logic [1:0]          core_req,
    input  wire logic                instr_last,
    input  wire logic                op_valid,
    input  wire iesc_pkg::iesc_byte_t opcode,
    input  wire iesc_pkg::iesc_addr_t core_pc,
    input  wire logic                flag_load,
    input  wire iesc_pkg::iesc_byte_t flag_in,
    input  wire iesc_pkg::iesc_byte_t mem_rdata,
    output iesc_pkg::iesc_addr_t     mem_addr,
    output iesc_pkg::iesc_byte_t     mem_wdata,
    output logic                     mem_wdata_oe,
    output logic                     address_strobe_n,
    output logic                     data_strobe_n,
    output logic                     read_write_n,
    output logic                     cpu_clk_en,
    output logic                     osc_en,
    output logic                     timer_run,
    output logic                     pc_load,
    output iesc_pkg::iesc_addr_t     pc_value,
    output iesc_pkg::iesc_byte_t     flag_value,
    output logic                     irq_out
);
    import iesc_pkg::*;

    localparam int NS = `IESC_NSRC;

    function automatic logic [1:0] slot_ph(input logic [7:0] c, input logic [7:0] s);
        slot_ph = (c == s) ? 2'h1 : (c == s + 8'h01) ? 2'h2 : (c == s + 8'h02) ? 2'h3 : 2'h0;
    endfunction

    function automatic logic [2:0] first_one(input logic [NS-1:0] v);
        first_one = 3'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_one = 3'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and request edges
    logic [3:0]    ext_lvl;
    logic [3:0]    ext_lvl_d_reg;
    logic [NS-1:0] new_req;

    iesc_pin_sync #(.W(4)) u_sync (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .pin_in    ({ext_request_line_3, ext_request_line_2,
                     ext_request_line_1, ext_request_line_0}),
        .level_out (ext_lvl)
    );

    // Falling edge requests on the lines, core requests taken as levels; lines keep sampling in every mode, stop included
    assign new_req = {core_req, ext_lvl_d_reg & ~ext_lvl};

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    iesc_mode_t    mode_reg, mode_next;
    logic [7:0]    cnt_reg, cnt_next;
    logic [2:0]    src_reg, src_next;
    logic [NS-1:0] pend_reg, pend_next;
    logic          prev_nop_reg, prev_nop_next;
    logic          boot_reg;
    logic [7:0]    vhi_reg, vhi_next, vlo_reg, vlo_next;
    iesc_addr_t    addr_reg, addr_next, pcv_reg, pcv_next;
    iesc_byte_t    wd_reg, wd_next;
    logic          oe_reg, oe_next, as_reg, as_next, ds_reg, ds_next, rw_reg, rw_next;
    logic          cen_reg, cen_next, osc_reg, osc_next, tmr_reg, tmr_next;
    logic          pcl_reg, pcl_next;
    logic          grant, wake, push, vec_done;
    logic [1:0]    ph_pcl, ph_pch, ph_flg, ph_vhi, ph_vlo;

    // Bus and register state
    logic          gie_reg, gie_next;
    logic [`IESC_STAT_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
    iesc_addr_t    sp_reg, sp_next;
    iesc_byte_t    flags_reg, flags_next;
    iesc_word_t    rd_reg, rd_next;
    logic          dp_wr_reg, dp_wr_next, irq_reg, irq_next;
    logic [7:0]    dp_ofs_reg, dp_ofs_next;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        mode_next     = mode_reg;
        cnt_next      = cnt_reg;
        src_next      = src_reg;
        prev_nop_next = op_valid ? (opcode == `IESC_OP_NOP) : prev_nop_reg;
        vhi_next      = vhi_reg;
        vlo_next      = vlo_reg;
        pcv_next      = pcv_reg;
        pcl_next      = boot_reg;
        grant         = 1'b0;
        wake          = 1'b0;
        vec_done      = 1'b0;
        case (mode_reg)
            IESC_RUN: begin
                // Sleep opcode only honoured right after a no-operation
                if (op_valid && prev_nop_reg && opcode == `IESC_OP_STOP) begin
                    mode_next = IESC_STOP;
                end else if (op_valid && prev_nop_reg && opcode == `IESC_OP_HALT) begin
                    mode_next = IESC_HALT;
                end else if (instr_last && gie_reg && |pend_reg) begin
                    grant     = 1'b1;
                    mode_next = IESC_ENTRY;
                    cnt_next  = 8'h01;
                    src_next  = first_one(pend_reg);
                end
            end
            IESC_ENTRY: begin
                cnt_next = cnt_reg + 8'h01;
                if (!ds_reg && rw_reg && cnt_reg == `IESC_SLOT_VHI + 8'h01) begin
                    vhi_next = mem_rdata;
                end
                if (!ds_reg && rw_reg && cnt_reg == `IESC_SLOT_VLO + 8'h01) begin
                    vlo_next = mem_rdata;
                end
                if (cnt_reg == 8'(`IESC_FETCH_CYC - 1)) begin
                    mode_next = IESC_RUN;
                    pcl_next  = 1'b1;
                    pcv_next  = {vhi_reg, vlo_reg};
                    vec_done  = 1'b1;
                end
            end
            IESC_HALT: begin
                if (|(pend_reg | new_req)) begin
                    mode_next = IESC_RUN;
                    wake      = 1'b1;
                end
            end
            IESC_STOP: begin
                mode_next = IESC_STOP;
            end
            default: begin
                mode_next = IESC_RUN;
            end
        endcase
        if (boot_reg) begin
            pcv_next = `IESC_RESTART_ADDR;
        end
        // Set wins over the grant's clear
        pend_next = (pend_reg & ~(grant ? NS'(1) << src_next : NS'(0))) | new_req;

        // External bus cycles driven from the coming count
        ph_pcl    = slot_ph(cnt_next, `IESC_SLOT_PCL);
        ph_pch    = slot_ph(cnt_next, `IESC_SLOT_PCH);
        ph_flg    = slot_ph(cnt_next, `IESC_SLOT_FLG);
        ph_vhi    = slot_ph(cnt_next, `IESC_SLOT_VHI);
        ph_vlo    = slot_ph(cnt_next, `IESC_SLOT_VLO);
        addr_next = addr_reg;
        wd_next   = wd_reg;
        as_next   = 1'b1;
        ds_next   = 1'b1;
        rw_next   = 1'b1;
        oe_next   = 1'b0;
        push      = 1'b0;
        if (mode_next == IESC_ENTRY) begin
            if ((ph_pcl | ph_pch | ph_flg) != 2'h0) begin
                rw_next = 1'b0;
                oe_next = 1'b1;
                as_next = (ph_pcl | ph_pch | ph_flg) != 2'h1;
                ds_next = (ph_pcl | ph_pch | ph_flg) != 2'h2;
                if ((ph_pcl | ph_pch | ph_flg) == 2'h1) begin
                    push      = 1'b1;
                    addr_next = sp_reg - 16'h0001;
                    wd_next   = (ph_pcl != 2'h0) ? core_pc[7:0] :
                                (ph_pch != 2'h0) ? core_pc[15:8] : flags_reg;
                end
            end
            if ((ph_vhi | ph_vlo) != 2'h0) begin
                as_next = (ph_vhi | ph_vlo) != 2'h1;
                ds_next = (ph_vhi | ph_vlo) != 2'h2;
                if (ph_vhi == 2'h1) begin
                    addr_next = `IESC_VEC_BASE + {12'h000, src_reg, 1'b0};
                end
                if (ph_vlo == 2'h1) begin
                    addr_next = `IESC_VEC_BASE + {12'h000, src_reg, 1'b1};
                end
            end
        end
        cen_next = mode_next != IESC_HALT && mode_next != IESC_STOP;
        osc_next = mode_next != IESC_STOP;
        tmr_next = mode_next != IESC_STOP;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_reg      <= IESC_RUN;
            cnt_reg       <= 8'h00;
            src_reg       <= 3'h0;
            pend_reg      <= '0;
            prev_nop_reg  <= 1'b0;
            boot_reg      <= 1'b1;
            vhi_reg       <= 8'h00;
            vlo_reg       <= 8'h00;
            addr_reg      <= 16'h0000;
            pcv_reg       <= 16'h0000;
            wd_reg        <= 8'h00;
            oe_reg        <= 1'b0;
            as_reg        <= 1'b1;
            ds_reg        <= 1'b1;
            rw_reg        <= 1'b1;
            cen_reg       <= 1'b1;
            osc_reg       <= 1'b1;
            tmr_reg       <= 1'b1;
            pcl_reg       <= 1'b0;
            ext_lvl_d_reg <= 4'hf;
        end else begin
            mode_reg      <= mode_next;
            cnt_reg       <= cnt_next;
            src_reg       <= src_next;
            pend_reg      <= pend_next;
            prev_nop_reg  <= prev_nop_next;
            boot_reg      <= 1'b0;
            vhi_reg       <= vhi_next;
            vlo_reg       <= vlo_next;
            addr_reg      <= addr_next;
            pcv_reg       <= pcv_next;
            wd_reg        <= wd_next;
            oe_reg        <= oe_next;
            as_reg        <= as_next;
            ds_reg        <= ds_next;
            rw_reg        <= rw_next;
            cen_reg       <= cen_next;
            osc_reg       <= osc_next;
            tmr_reg       <= tmr_next;
            pcl_reg       <= pcl_next;
            ext_lvl_d_reg <= ext_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave and registers; zero wait states, always OKAY
    always_comb begin
        gie_next    = grant ? 1'b0 : gie_reg;
        stat_next   = stat_reg;
        mask_next   = mask_reg;
        sp_next     = push ? sp_reg - 16'h0001 : sp_reg;
        flags_next  = flag_load ? {flag_in[7:`IESC_FLAG_LSB], 2'b00} : flags_reg;
        dp_wr_next  = hsel && htrans[1] && hready && hwrite;
        dp_ofs_next = haddr[7:0];
        rd_next     = 32'h0000_0000;
        if (dp_wr_reg) begin
            case (dp_ofs_reg)
                `IESC_CTRL_OFS:  gie_next  = hwdata[`IESC_CTRL_GIE] && !grant;
                `IESC_STAT_OFS:  stat_next = stat_reg & ~hwdata[`IESC_STAT_W-1:0];
                `IESC_MASK_OFS:  mask_next = hwdata[`IESC_STAT_W-1:0];
                `IESC_SP_OFS:    sp_next   = hwdata[15:0];
                `IESC_FLAGS_OFS: flags_next = {hwdata[7:`IESC_FLAG_LSB], 2'b00};
                default: begin
                end
            endcase
        end
        // Hardware events set after the software clear
        stat_next = stat_next | {wake, vec_done, grant};
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                `IESC_CTRL_OFS:  rd_next = {31'h0, gie_reg};
                `IESC_STAT_OFS:  rd_next = {29'h0, stat_reg};
                `IESC_MASK_OFS:  rd_next = {29'h0, mask_reg};
                `IESC_PEND_OFS:  rd_next = {26'h0, pend_reg};
                `IESC_SP_OFS:    rd_next = {16'h0, sp_reg};
                `IESC_MODE_OFS:  rd_next = {21'h0, src_reg, 6'h0, mode_reg};
                `IESC_FLAGS_OFS: rd_next = {24'h0, flags_reg};
                default:         rd_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gie_reg    <= 1'b0;
            stat_reg   <= '0;
            mask_reg   <= '0;
            sp_reg     <= `IESC_SP_RST;
            flags_reg  <= `IESC_FLAGS_RST;
            rd_reg     <= 32'h0000_0000;
            dp_wr_reg  <= 1'b0;
            dp_ofs_reg <= 8'h00;
            irq_reg    <= 1'b0;
        end else begin
            gie_reg    <= gie_next;
            stat_reg   <= stat_next;
            mask_reg   <= mask_next;
            sp_reg     <= sp_next;
            flags_reg  <= flags_next;
            rd_reg     <= rd_next;
            dp_wr_reg  <= dp_wr_next;
            dp_ofs_reg <= dp_ofs_next;
            irq_reg    <= irq_next;
        end
    end

    assign hrdata           = rd_reg;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign mem_addr         = addr_reg;
    assign mem_wdata        = wd_reg;
    assign mem_wdata_oe     = oe_reg;
    assign address_strobe_n = as_reg;
    assign data_strobe_n    = ds_reg;
    assign read_write_n     = rw_reg;
    assign cpu_clk_en       = cen_reg;
    assign osc_en           = osc_reg;
    assign timer_run        = tmr_reg;
    assign pc_load          = pcl_reg;
    assign pc_value         = pcv_reg;
    assign flag_value       = flags_reg;
    assign irq_out          = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_stacking;
        (mode_reg == IESC_ENTRY) [*8];
    endsequence
    sequence s_fetch;
        ##57 (pc_load && pc_value == {vhi_reg, vlo_reg});
    endsequence

    a_grant_stacks: assert property (grant |=> s_stacking)
        else $error("entry did not start after grant");
    a_push_window: assert property (!rw_reg |-> cnt_reg <= 8'(`IESC_STACK_CYC))
        else $error("stack write outside stacking window");
    a_vec_window: assert property ((!ds_reg && rw_reg) |->
                                   cnt_reg > 8'(`IESC_STACK_CYC) &&
                                   cnt_reg < 8'(`IESC_FETCH_CYC))
        else $error("vector read outside its window");
    a_fetch_time: assert property (grant |=> s_fetch)
        else $error("service fetch not at cycle 58");
    a_halt_clocks: assert property (mode_reg == IESC_HALT |->
                                    !cpu_clk_en && osc_en && timer_run)
        else $error("halt clocks wrong");
    a_halt_wake: assert property ((mode_reg == IESC_HALT && |new_req) |=>
                                  mode_reg == IESC_RUN)
        else $error("halt not left on interrupt");
    a_halt_pins: assert property (mode_reg == IESC_HALT |->
                                  address_strobe_n && data_strobe_n && read_write_n)
        else $error("strobes not high in halt");
    a_halt_hold: assert property ((mode_reg == IESC_HALT && $past(mode_reg) == IESC_HALT) |->
                                  $stable(mem_addr) && $stable(mem_wdata))
        else $error("outputs changed in halt");
    a_stop_stays: assert property (mode_reg == IESC_STOP |=>
                                   mode_reg == IESC_STOP && !osc_en && !cpu_clk_en)
        else $error("stop left without reset");
    a_sample_point: assert property (grant |-> instr_last)
        else $error("grant outside last instruction cycle");
    a_grant_masks: assert property (grant |=> !gie_reg ##1 !grant)
        else $error("interrupts not disabled by grant");
    a_flag_lsbs: assert property (flag_value[1:0] == 2'b00 && $stable(hreadyout))
        else $error("unused flag bits set");
endmodule
